/* test/fskte_host_model.sv */
// fskte_host_model: host that feeds serial transmit bits to the encoder
// assumes bits go out on the data clock fall and are captured on its rise
`timescale 1ns/1ps
module fskte_host_model (
  input  wire logic        mclk_in,
  input  wire logic        clk_pin_in,
  input  wire logic [15:0] switch_at_in,
  input  wire logic        lo_bit_in,
  input  wire logic        hi_bit_in,
  output logic             data_out,
  output logic [15:0]      rises_out
);
  logic pin_q = 1'b0;
  initial data_out = 1'b0;
  initial rises_out = 16'h0000;
  // count rises; next bit goes out on the fall, long before the next capture
  always @(posedge mclk_in) begin
    pin_q <= clk_pin_in;
    if (clk_pin_in && !pin_q) begin
      rises_out <= rises_out + 16'h0001;
    end
    if (!clk_pin_in && pin_q) begin
      data_out <= (rises_out >= switch_at_in) ? hi_bit_in : lo_bit_in;
    end
  end
endmodule

/* test/test_fsk_transmit_modulation_encoder.sv */
// test_fsk_transmit_modulation_encoder: self-checking bench for fskte_top
// assumes the host model drives the data pin; dividers stay at one
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module test_fsk_transmit_modulation_encoder
  import fskte_pkg::*;
;
  logic               mclk_in = 1'b0;
  logic               rst_n_in = 1'b0;
  logic [7:0]         addr_in = 8'h00;
  logic [31:0]        wdata_in = 32'h0000_0000;
  logic               wr_in = 1'b0;
  logic               rd_in = 1'b0;
  logic [31:0]        rdata_out;
  wire logic          transfer_data_pin_in;
  logic               transfer_clock_pin_out;
  logic               symbol_tick_out;
  logic               tx_active_out;
  logic signed [2:0]  level_out;
  logic signed [12:0] dev_offset_out;
  logic [1:0]         filter_out;
  logic [15:0]        switch_at = 16'hffff;
  logic [15:0]        rises;
  logic               lo_bit = 1'b0;
  logic               hi_bit = 1'b0;
  int                 failures = 0;
  int                 checks_done = 0;

  fskte_top u_fskte_top (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .transfer_data_pin_in(transfer_data_pin_in),
    .transfer_clock_pin_out(transfer_clock_pin_out), .level_out(level_out),
    .dev_offset_out(dev_offset_out), .filter_out(filter_out),
    .symbol_tick_out(symbol_tick_out), .tx_active_out(tx_active_out));
  fskte_host_model u_fskte_host_model (
    .mclk_in(mclk_in), .clk_pin_in(transfer_clock_pin_out), .switch_at_in(switch_at),
    .lo_bit_in(lo_bit), .hi_bit_in(hi_bit), .data_out(transfer_data_pin_in),
    .rises_out(rises));

  // 100 mhz master clock
  always #5 mclk_in = ~mclk_in;

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  // word2 with five deviation steps
  function automatic logic [31:0] w2(input logic [2:0] m, input logic a);
    return {1'b0, a, 2'b00, 9'h005, 12'h000, m, 4'h0};
  endfunction
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (symbol_tick_out !== 1'b1 && n < 400);
  endtask
  // hold the data line steady long enough to flush any latency
  task automatic send_const(input logic b);
    lo_bit <= b;
    hi_bit <= b;
    switch_at <= 16'hffff;
    cyc(400);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    rd(FSKTE_OFS_WORD0, d); `CHK(d, FSKTE_RST_WORD0)
    rd(FSKTE_OFS_WORD1, d); `CHK(d, FSKTE_RST_WORD1)
    rd(FSKTE_OFS_WORD2, d); `CHK(d, FSKTE_RST_WORD2)
    rd(FSKTE_OFS_WORD3, d); `CHK(d, FSKTE_RST_WORD3)
    wr(FSKTE_OFS_WORD2, 32'h4ff8_0070);
    rd(FSKTE_OFS_WORD2, d); `CHK(d, 32'h4ff8_0070)
    wr(8'h14, 32'hffff_ffff);
    rd(8'h14, d); `CHK(d, 32'h0000_0000)
    $display("test registers done");
  endtask

  task automatic t_filter;
    fskte_filt_t e;
    for (int i = 0; i < 16; i++) begin
      wr(FSKTE_OFS_WORD2, w2(i[2:0], i[3]));
      cyc(3);
      e = (i[2:0] == 3'h1) ? FSKTE_F_GAUSS : FSKTE_F_NONE;
      if (i[2] && i[2:0] != 3'h4) e = i[3] ? FSKTE_F_RC_WIDE : FSKTE_F_RC_NARR;
      `CHK(filter_out, e)
    end
    $display("test filter select done");
  endtask

  task automatic t_clock;
    logic seen;
    time t0;
    wr(FSKTE_OFS_WORD2, w2(3'h0, 1'b0));
    cyc(50);
    `CHK(transfer_clock_pin_out, 1'b0)
    wr(FSKTE_OFS_WORD3, {14'h0000, 8'h01, 4'h1, 6'h00});
    t0 = $time;
    @(posedge transfer_clock_pin_out);
    `CHK(($time - t0) <= 400, 1'b1)
    t0 = $time;
    @(posedge transfer_clock_pin_out);
    `CHK(($time - t0) / 10, 64'd32)
    `CHK(tx_active_out, 1'b1)
    wr(FSKTE_OFS_WORD2, w2(3'h4, 1'b0));
    cyc(40);
    seen = 1'b0;
    repeat (100) begin
      cyc(1);
      seen = seen | transfer_clock_pin_out;
    end
    `CHK(seen, 1'b0)
    wr(FSKTE_OFS_WORD2, w2(3'h0, 1'b0));
    $display("test data clock done");
  endtask

  // cycles from the capturing rise of the first one to its level
  task automatic t_latency(input logic [2:0] m, input logic a, input int lat);
    int n;
    wr(FSKTE_OFS_WORD2, w2(m, a));
    send_const(1'b0);
    `CHK(level_out, -3'sd1)
    switch_at <= rises + 16'h0003;
    hi_bit <= 1'b1;
    n = 0;
    while (rises !== switch_at && n < 400) begin
      cyc(1);
      n++;
    end
    @(posedge transfer_clock_pin_out);
    n = 0;
    while (level_out !== 3'sd1 && n < 400) begin
      cyc(1);
      n++;
    end
    `CHK(n, lat * 32)
    $display("test latency mode %0d done", m);
  endtask

  task automatic t_quad;
    int g;
    wr(FSKTE_OFS_WORD2, w2(3'h3, 1'b0));
    send_const(1'b0);
    `CHK(level_out, -3'sd3)
    `CHK(dev_offset_out, -13'sd30)
    wait_tick(g);
    wait_tick(g);
    `CHK(g, 64)
    send_const(1'b1);
    `CHK(level_out, 3'sd1)
    `CHK(dev_offset_out, 13'sd10)
    wr(FSKTE_OFS_WORD1, 32'h0004_0000);
    cyc(80);
    `CHK(dev_offset_out, 13'sd5)
    wr(FSKTE_OFS_WORD1, 32'h0000_0000);
    $display("test four level done");
  endtask

  task automatic t_tri;
    int g;
    logic signed [2:0] v [6];
    wr(FSKTE_OFS_WORD2, w2(3'h2, 1'b0));
    send_const(1'b0);
    `CHK(level_out, 3'sd0)
    send_const(1'b1);
    for (int i = 0; i < 6; i++) begin
      wait_tick(g);
      v[i] = level_out;
      if (i > 0) `CHK(g, 32)
    end
    `CHK(v[0] == 3'sd1 || v[0] == -3'sd1, 1'b1)
    for (int i = 0; i < 4; i++) `CHK(v[i + 2], -v[i])
    $display("test three level done");
  endtask

  task automatic t_txrx;
    logic [31:0] d;
    wr(FSKTE_OFS_WORD0, 32'h0800_0000);
    cyc(5);
    `CHK(tx_active_out, 1'b0)
    `CHK(level_out, 3'sd0)
    rd(FSKTE_OFS_STATUS, d);
    `CHK(d[1:0], 2'b10)
    wr(FSKTE_OFS_WORD0, 32'h0000_0000);
    cyc(5);
    `CHK(tx_active_out, 1'b1)
    $display("test transmit select done");
  endtask

  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    cyc(2);
    t_regs();
    t_filter();
    t_clock();
    t_latency(3'h0, 1'b0, 1);
    t_latency(3'h1, 1'b0, 4);
    t_latency(3'h5, 1'b0, 5);
    t_latency(3'h5, 1'b1, 4);
    t_quad();
    t_tri();
    t_txrx();
    results();
  end
  // watchdog, twenty thousand cycles
  initial begin
    #200000;
    failures++;
    results();
  end
endmodule

/* verilog/fskte_clkdiv.sv */
// fskte_clkdiv: data clock and 32x oversample enables from the master clock
// assumes dividers are static while running; zero divider counts as one
`timescale 1ns/1ps
module fskte_clkdiv
  import fskte_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     rst_n_in,
  input  wire logic                     run_in,
  input  wire logic [FSKTE_DEMOD_W-1:0] demod_div_in,
  input  wire logic [FSKTE_CDR_W-1:0]   cdr_div_in,
  output logic                          os_tick_out,
  output logic                          rise_out,
  output logic                          fall_out,
  output logic                          clk_level_out
);
  logic [11:0] pre_cnt;
  logic [4:0]  phase;
  wire  [3:0]  demod_eff = (demod_div_in == 4'h0) ? 4'h1 : demod_div_in;
  wire  [7:0]  cdr_eff   = (cdr_div_in == 8'h00) ? 8'h01 : cdr_div_in;
  wire  [11:0] pre_last  = 12'(demod_eff * cdr_eff) - 12'h001;
  wire         pre_wrap  = run_in && (pre_cnt == pre_last);

  // prescaler by demod*cdr, then 32 phases per data clock period
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !run_in) begin
      pre_cnt <= 12'h000;
      phase   <= 5'h00;
    end else if (pre_wrap) begin
      pre_cnt <= 12'h000;
      phase   <= phase + 5'h01;
    end else begin
      pre_cnt <= pre_cnt + 12'h001;
    end
  end

  assign os_tick_out   = pre_wrap;
  assign rise_out      = pre_wrap && (phase == FSKTE_HALF_PHASE);
  assign fall_out      = pre_wrap && (phase == FSKTE_LAST_PHASE);
  assign clk_level_out = phase[4];
endmodule

/* verilog/fskte_pkg.sv */
// fskte_pkg: shared constants and types for the fsk transmit encoder
// assumes a 32-bit register port with byte offsets on an 8-bit address
package fskte_pkg;

  // register byte offsets
  localparam logic [7:0] FSKTE_OFS_WORD0  = 8'h00;
  localparam logic [7:0] FSKTE_OFS_WORD1  = 8'h04;
  localparam logic [7:0] FSKTE_OFS_WORD2  = 8'h08;
  localparam logic [7:0] FSKTE_OFS_WORD3  = 8'h0c;
  localparam logic [7:0] FSKTE_OFS_STATUS = 8'h10;

  // values after reset
  localparam logic [31:0] FSKTE_RST_WORD0 = 32'h0000_0000;
  localparam logic [31:0] FSKTE_RST_WORD1 = 32'h0000_0000;
  localparam logic [31:0] FSKTE_RST_WORD2 = 32'h0000_0000;
  localparam logic [31:0] FSKTE_RST_WORD3 = 32'h0000_0000;

  // field positions
  localparam int FSKTE_W0_TXRX_BIT  = 27;
  localparam int FSKTE_W1_HALVE_BIT = 18;
  localparam int FSKTE_W2_MOD_LSB   = 4;
  localparam int FSKTE_W2_DEV_LSB   = 19;
  localparam int FSKTE_W2_INV_LSB   = 28;
  localparam int FSKTE_W2_ALPHA_BIT = 30;
  localparam int FSKTE_W3_DEMOD_LSB = 6;
  localparam int FSKTE_W3_CDR_LSB   = 10;

  // field widths
  localparam int FSKTE_DEMOD_W = 4;
  localparam int FSKTE_CDR_W   = 8;
  localparam int FSKTE_DEV_W   = 9;

  // oversampling ratio of the data clock and its half
  localparam int unsigned FSKTE_OVERSAMPLE = 32;
  localparam logic [4:0]  FSKTE_HALF_PHASE = 5'h0f;
  localparam logic [4:0]  FSKTE_LAST_PHASE = 5'h1f;

  // latency in bit or symbol periods
  localparam logic [2:0] FSKTE_LAT_PLAIN   = 3'h1;
  localparam logic [2:0] FSKTE_LAT_SHAPED  = 3'h4;
  localparam logic [2:0] FSKTE_LAT_RC_NARR = 3'h5;
  localparam int         FSKTE_PIPE_DEPTH  = 5;

  // modulation select codes
  typedef enum logic [2:0] {
    FSKTE_M_BIN    = 3'h0,
    FSKTE_M_GAUSS  = 3'h1,
    FSKTE_M_TRI    = 3'h2,
    FSKTE_M_QUAD   = 3'h3,
    FSKTE_M_OVS    = 3'h4,
    FSKTE_M_RC_BIN = 3'h5,
    FSKTE_M_RC_TRI = 3'h6,
    FSKTE_M_RC_QUAD= 3'h7
  } fskte_mod_t;

  // prefilter selection shown to the shaping stage
  typedef enum logic [1:0] {
    FSKTE_F_NONE    = 2'h0,
    FSKTE_F_GAUSS   = 2'h1,
    FSKTE_F_RC_NARR = 2'h2,
    FSKTE_F_RC_WIDE = 2'h3
  } fskte_filt_t;

endpackage

/* verilog/fskte_top.sv */
// fskte_top: transmit modulation encoder with register port and data pins
// assumes the transfer data pin is asynchronous; register port is synchronous
// Operation
// - data clock is crystal over demod divider times recovery divider times 32
// - demod divider at word3 bits 6-9, recovery divider at bits 10-17
// - deviation is comparison frequency times steps over 65536, halved if selected
// - nine-bit deviation steps at word2 bits 19-27, 1 to 511, all modes
// - four-level symbols sit at plus/minus one and three deviations
// - code 000 selects binary, transmit bit toggles about center
// - three-level zero is center, nonzero is center plus or minus deviation
// - precode bit xor precode two back, output precode minus precode two back
// - three-level encoder makes exactly one symbol per input bit
// - code 010 is plain three-level, 110 is raised-cosine three-level
// - four-level pairs bits, gray maps, half bit rate, code 011
// - data clock starts when word3 written; host gives msb on first pulse
// - code 100 drives no clock, samples data pin at 32 times rate
// - gaussian prefilter, bt 0.5, only binary, code 001
// - raised-cosine roll-off 0.5, becomes 0.7 when word2 bit 30 set
// - raised-cosine codes 101 binary, 110 three-level, 111 four-level
// - latency one plain, four gaussian or wide roll-off, five narrow roll-off
// - sample on rising edge; inverting via word2 bits 28-29 adds half period
// - transmit is selected when word0 bit 27 is zero
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
module fskte_top
  import fskte_pkg::*;
(
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  input  wire logic [7:0]         addr_in,
  input  wire logic [31:0]        wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic      [31:0]        rdata_out,
  input  wire logic               transfer_data_pin_in,
  output logic                    transfer_clock_pin_out,
  output logic signed [2:0]       level_out,
  output logic signed [12:0]      dev_offset_out,
  output logic      [1:0]         filter_out,
  output logic                    symbol_tick_out,
  output logic                    tx_active_out
);
  // configuration words and clock start flag
  logic [31:0] word0;
  logic [31:0] word1;
  logic [31:0] word2;
  logic [31:0] word3;
  logic        clk_run;

  // register decode
  wire sel_w0  = (addr_in == FSKTE_OFS_WORD0);
  wire sel_w1  = (addr_in == FSKTE_OFS_WORD1);
  wire sel_w2  = (addr_in == FSKTE_OFS_WORD2);
  wire sel_w3  = (addr_in == FSKTE_OFS_WORD3);
  wire sel_st  = (addr_in == FSKTE_OFS_STATUS);
  wire wr_w3   = wr_in && sel_w3;

  // configuration writes; word3 write starts the data clock
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      word0   <= FSKTE_RST_WORD0;
      word1   <= FSKTE_RST_WORD1;
      word2   <= FSKTE_RST_WORD2;
      word3   <= FSKTE_RST_WORD3;
      clk_run <= 1'b0;
    end else if (wr_in) begin
      if (sel_w0) word0 <= wdata_in;
      if (sel_w1) word1 <= wdata_in;
      if (sel_w2) word2 <= wdata_in;
      if (sel_w3) word3 <= wdata_in;
      if (sel_w3) clk_run <= 1'b1;
    end
  end

  // field extraction
  wire fskte_mod_t           mode      = fskte_mod_t'(word2[FSKTE_W2_MOD_LSB +: 3]);
  wire [FSKTE_DEV_W-1:0]     dev_raw   = word2[FSKTE_W2_DEV_LSB +: FSKTE_DEV_W];
  wire [FSKTE_DEV_W-1:0]     dev_steps = (dev_raw == 9'h000) ? 9'h001 : dev_raw;
  wire [1:0]                 inv_sel   = word2[FSKTE_W2_INV_LSB +: 2];
  wire                       alpha_wide = word2[FSKTE_W2_ALPHA_BIT];
  wire                       halve     = word1[FSKTE_W1_HALVE_BIT];
  wire [FSKTE_DEMOD_W-1:0]   demod_div = word3[FSKTE_W3_DEMOD_LSB +: FSKTE_DEMOD_W];
  wire [FSKTE_CDR_W-1:0]     cdr_div   = word3[FSKTE_W3_CDR_LSB +: FSKTE_CDR_W];
  wire                       tx_sel    = !word0[FSKTE_W0_TXRX_BIT];
  wire                       tx_active = tx_sel && clk_run;

  // mode class decode
  wire m_ovs  = (mode == FSKTE_M_OVS);
  wire m_tri  = (mode == FSKTE_M_TRI) || (mode == FSKTE_M_RC_TRI);
  wire m_quad = (mode == FSKTE_M_QUAD) || (mode == FSKTE_M_RC_QUAD);
  wire m_rc   = (mode == FSKTE_M_RC_BIN) || (mode == FSKTE_M_RC_TRI)
             || (mode == FSKTE_M_RC_QUAD);
  wire m_gau  = (mode == FSKTE_M_GAUSS);

  // prefilter choice and its latency
  wire fskte_filt_t filt = m_gau ? FSKTE_F_GAUSS
                         : !m_rc ? FSKTE_F_NONE
                         : alpha_wide ? FSKTE_F_RC_WIDE : FSKTE_F_RC_NARR;
  wire [2:0] lat = (filt == FSKTE_F_NONE)    ? FSKTE_LAT_PLAIN
                 : (filt == FSKTE_F_RC_NARR) ? FSKTE_LAT_RC_NARR
                 : FSKTE_LAT_SHAPED;

  // data clock divider
  logic os_tick;
  logic clk_rise;
  logic clk_fall;
  logic clk_level;
  fskte_clkdiv u_div (
    .mclk_in       (mclk_in),
    .rst_n_in      (rst_n_in),
    .run_in        (clk_run),
    .demod_div_in  (demod_div),
    .cdr_div_in    (cdr_div),
    .os_tick_out   (os_tick),
    .rise_out      (clk_rise),
    .fall_out      (clk_fall),
    .clk_level_out (clk_level)
  );

  // clock pin is silent in oversampled mode and before word3
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      transfer_clock_pin_out <= 1'b0;
    end else begin
      transfer_clock_pin_out <= clk_level && !m_ovs && clk_run;
    end
  end

  // two-stage synchroniser on the data pin
  logic din_meta;
  logic din_sync;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end else begin
      din_meta <= transfer_data_pin_in;
      din_sync <= din_meta;
    end
  end

  // sampling and update moments; inverted clock samples half a period late
  wire edge_smp = (inv_sel != 2'b00) ? clk_fall : clk_rise;
  wire smp_tick = tx_active && (m_ovs ? os_tick : edge_smp);
  wire upd_tick = tx_active && (m_ovs ? os_tick : clk_rise);

  // three-level encoder
  logic signed [2:0] tri_level;
  logic              tri_valid;
  fskte_tri_enc u_tri (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .clear_in     (!m_tri || !tx_active),
    .bit_valid_in (smp_tick && m_tri),
    .bit_in       (din_sync),
    .level_out    (tri_level),
    .valid_out    (tri_valid)
  );

  // four-level pairing: first bit is the msb
  logic pair_half;
  logic pair_msb;
  wire  pair_done = smp_tick && m_quad && pair_half;
  wire  signed [2:0] quad_level = ({pair_msb, din_sync} == 2'b00) ? -3'sd3
                                : ({pair_msb, din_sync} == 2'b01) ? -3'sd1
                                : ({pair_msb, din_sync} == 2'b11) ?  3'sd1
                                :  3'sd3;
  wire  signed [2:0] bin_level  = din_sync ? 3'sd1 : -3'sd1;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !m_quad || !tx_active) begin
      pair_half <= 1'b0;
      pair_msb  <= 1'b0;
    end else if (smp_tick) begin
      pair_half <= !pair_half;
      pair_msb  <= din_sync;
    end
  end

  // pending symbol waits for the next update moment
  logic signed [2:0] pend_level;
  logic              pend_new;
  wire  bin_new   = smp_tick && !m_tri && !m_quad;
  wire  take_new  = bin_new || pair_done || (tri_valid && m_tri);
  wire  signed [2:0] next_pend = pair_done ? quad_level
                               : bin_new   ? bin_level
                               : tri_level;
  wire  shift_tick = upd_tick && pend_new;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || !tx_active) begin
      pend_level <= 3'sh0;
      pend_new   <= 1'b0;
    end else if (take_new) begin
      pend_level <= next_pend;
      pend_new   <= 1'b1;
    end else if (shift_tick) begin
      pend_new   <= 1'b0;
    end
  end

  // latency line of symbols, one stage per symbol period
  logic signed [2:0] pipe [FSKTE_PIPE_DEPTH];
  genvar gi;
  generate
    for (gi = 0; gi < FSKTE_PIPE_DEPTH; gi++) begin : g_pipe
      always_ff @(posedge mclk_in) begin
        if (!rst_n_in || !tx_active) begin
          pipe[gi] <= 3'sh0;
        end else if (shift_tick) begin
          pipe[gi] <= (gi == 0) ? pend_level : pipe[(gi == 0) ? 0 : gi - 1];
        end
      end
    end
  endgenerate

  // deviation offset in units of comparison frequency over 2^17
  wire signed [2:0]  out_level = pipe[lat - 3'h1];
  wire signed [12:0] lev_ext   = 13'(out_level);
  wire signed [12:0] dev_ext   = signed'({4'h0, dev_steps});
  wire signed [12:0] prod      = 13'(lev_ext * dev_ext);
  wire signed [12:0] next_dev  = halve ? prod : 13'(prod <<< 1);

  // registered data outputs
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      level_out       <= 3'sh0;
      dev_offset_out  <= 13'sh0;
      filter_out      <= FSKTE_F_NONE;
      symbol_tick_out <= 1'b0;
      tx_active_out   <= 1'b0;
    end else begin
      level_out       <= tx_active ? out_level : 3'sh0;
      dev_offset_out  <= tx_active ? next_dev : 13'sh0;
      filter_out      <= filt;
      symbol_tick_out <= shift_tick;
      tx_active_out   <= tx_active;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  wire [31:0] status = {16'h0000, 5'h00, lat, filt, out_level, pair_half,
                        clk_run, tx_active};
  wire [31:0] next_rdata = !rd_in ? 32'h0000_0000
                         : sel_w0 ? word0
                         : sel_w1 ? word1
                         : sel_w2 ? word2
                         : sel_w3 ? word3
                         : sel_st ? status
                         : 32'h0000_0000;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= next_rdata;
    end
  end

  // assertion helpers: cycles since last rising data clock moment
  logic [17:0] per_cnt;
  logic        per_ok;
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || wr_w3) begin
      per_cnt <= 18'h0;
      per_ok  <= 1'b0;
    end else if (clk_rise) begin
      per_cnt <= 18'h1;
      per_ok  <= 1'b1;
    end else begin
      per_cnt <= per_cnt + 18'h1;
    end
  end
  wire [17:0] per_exp = 18'(((demod_div == 4'h0) ? 18'h1 : 18'(demod_div))
                      * ((cdr_div == 8'h00) ? 18'h1 : 18'(cdr_div))
                      * 18'(FSKTE_OVERSAMPLE));

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // checks beside the logic they guard
  a_clk_period: assert property (clk_rise && per_ok && !wr_in |-> per_cnt == per_exp)
    else $error("data clock period differs from dividers times 32");
  a_clk_silent: assert property ((m_ovs || !clk_run) |=> !transfer_clock_pin_out)
    else $error("clock pin active in oversampled mode or before start");
  a_clk_start: assert property ($rose(clk_run) |-> $past(wr_w3))
    else $error("data clock started without word3 write");
  a_tx_gate: assert property (!tx_sel |=> level_out == 3'sh0 && !tx_active_out)
    else $error("symbol output while receive selected");
  a_dev_scale: assert property (tx_active |=> dev_offset_out
                == ($past(halve) ? $past(prod) : 13'($past(prod) <<< 1)))
    else $error("deviation offset not scaled by level and step count");
  a_tri_levels: assert property (tri_valid && m_tri |-> tri_level inside {-3'sd1, 3'sd0, 3'sd1})
    else $error("three-level encoder out of range");
  a_quad_levels: assert property (pair_done |=> pend_level inside
                {-3'sd3, -3'sd1, 3'sd1, 3'sd3})
    else $error("four-level symbol not an odd level");
  a_quad_pair: assert property (smp_tick && m_quad && !pair_half
                |-> !take_new ##1 pair_half)
    else $error("four-level symbol emitted on first bit of pair");
  a_bin_levels: assert property (bin_new |=> pend_level inside {-3'sd1, 3'sd1})
    else $error("binary symbol not plus or minus one");
  a_tri_rate: assert property (smp_tick && m_tri ##1 tx_active && m_tri |-> tri_valid)
    else $error("three-level encoder dropped a bit");
  a_lat_plain: assert property (shift_tick && lat == FSKTE_LAT_PLAIN && $stable(lat)
                ##1 tx_active && lat == FSKTE_LAT_PLAIN
                |=> level_out == $past(pend_level, 2))
    else $error("plain latency is not one symbol");
  a_lat_select: assert property (m_rc && !alpha_wide |-> lat == FSKTE_LAT_RC_NARR)
    else $error("narrow roll-off latency not five");
  a_smp_edge: assert property (smp_tick && !m_ovs && inv_sel == 2'b00 |-> clk_rise)
    else $error("default sampling not on rising edge");
  a_gauss_bin: assert property (filt == FSKTE_F_GAUSS |-> !m_tri && !m_quad)
    else $error("gaussian filter outside binary mode");

  c_quad_sym: cover property (pair_done ##[1:40] shift_tick);
  c_tri_zero: cover property (tri_valid && m_tri && tri_level == 3'sd0);
  c_rc_narrow: cover property (tx_active && lat == FSKTE_LAT_RC_NARR && shift_tick);
  c_ovs_smp: cover property (m_ovs && smp_tick);
endmodule

/* verilog/fskte_tri_enc.sv */
// fskte_tri_enc: three-level precoder and 1-D^2 encoder, one symbol per bit
// assumes bit_valid_in pulses once per sampled bit
`timescale 1ns/1ps
module fskte_tri_enc
  import fskte_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              clear_in,
  input  wire logic              bit_valid_in,
  input  wire logic              bit_in,
  output logic signed [2:0]      level_out,
  output logic                   valid_out
);
  logic       pre_d1;
  logic       pre_d2;
  wire        pre_now = bit_in ^ pre_d2;
  wire  [2:0] diff    = 3'({2'b00, pre_now}) - 3'({2'b00, pre_d2});

  // precoder history and registered encoder output
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in || clear_in) begin
      pre_d1    <= 1'b0;
      pre_d2    <= 1'b0;
      level_out <= 3'sh0;
      valid_out <= 1'b0;
    end else begin
      valid_out <= bit_valid_in;
      if (bit_valid_in) begin
        pre_d1    <= pre_now;
        pre_d2    <= pre_d1;
        level_out <= signed'(diff);
      end
    end
  end
endmodule
